// File: common/ers_pkg.sv
// Purpose: Shared constants and types for the embedded RAM block
// Assumes: One core clock at 25 MHz; register offsets are byte addresses
// Notes:   Memory address and data widths derive from these names
`default_nettype none
package ers_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int ERS_AW = 8;
    localparam int ERS_DW = 16;
    localparam int ERS_DEPTH = 256;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ERS_OFF_CTRL   = 8'h00;
    localparam logic [7:0] ERS_OFF_STATUS = 8'h04;
    localparam logic [7:0] ERS_OFF_WIDTH  = 8'h08;
    localparam logic [7:0] ERS_OFF_LDADDR = 8'h0C;
    localparam logic [7:0] ERS_OFF_LDDATA = 8'h10;
    localparam int ERS_CTRL_DUAL  = 0;
    localparam int ERS_CTRL_LUT   = 1;
    localparam int ERS_CTRL_CFG   = 2;
    localparam logic [4:0] ERS_WIDTH_RST = 5'h10;
    localparam logic [1:0] ERS_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] ERS_HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] { ERS_SINGLE, ERS_DUAL, ERS_LUT } ers_mode_type;

    // ****************************************
    // Port carriers
    // ****************************************
    typedef struct packed {
        logic              req;
        logic              we;
        logic [ERS_AW-1:0] addr;
        logic [ERS_DW-1:0] data;
    } ers_wr_type;

    typedef struct packed {
        logic              req;
        logic [ERS_AW-1:0] addr;
    } ers_rd_type;

    typedef struct packed {
        logic              sel;
        logic              write;
        logic [7:0]        addr;
    } ers_ahb_type;
endpackage
`default_nettype wire

// File: logic/ers_ram.sv
// Purpose: Embedded RAM block: single-port, dual-port or lookup-table use
// Assumes: Read and write ports synchronous to core_clk; AHB-Lite slave
// Notes:   Lookup-table contents loaded over the bus in config state
//
// Functional notes
// R1: Registered inputs and registered read output
// R2: Lookup table preloaded, then read-only
// R3: Lookup table: 8 inputs, 16 outputs
// R4: Single-port or dual-port configuration
// R5: Separate read and write section timing
// R6: Per-section synchronous clock enables hold state
// R7: Word width configurable up to 16
// R8: Internal write strobe from write clock
// R9: Read data one enabled edge later
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`default_nettype none
module ers_ram
    import ers_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire ers_wr_type        wr_in,
    input  wire ers_rd_type        rd_in,
    output logic [ERS_DW-1:0]      rd_data,
    output logic                   rd_valid,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        ers_wr_type        wr;
        ers_rd_type        rd;
        logic              rd_stage;
        logic [ERS_DW-1:0] dout;
        logic              dvalid;
        ers_mode_type      mode;
        logic              cfg;
        logic [4:0]        width;
        logic [ERS_AW-1:0] ld_addr;
        ers_ahb_type       ap;
        logic [31:0]       hrdata;
    } ers_state_type;

    ers_state_type state_r;
    ers_state_type state_nxt;
    logic [ERS_DW-1:0] mem [ERS_DEPTH];
    logic              mem_we;
    logic [ERS_AW-1:0] mem_wa;
    logic [ERS_DW-1:0] mem_wd;
    logic [ERS_DW-1:0] mem_q;

    function automatic logic [ERS_DW-1:0] width_mask(input logic [4:0] w);
        logic [ERS_DW-1:0] m;
        m = '0;
        for (int i = 0; i < ERS_DW; i++) begin
            if (i < int'(w)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        mem_we = 1'b0;
        mem_wa = state_r.wr.addr;
        mem_wd = state_r.wr.data & width_mask(state_r.width);     // R7
        // Read before write: a same-edge write is not seen
        mem_q  = mem[state_r.rd.addr];
        // Single-port shares the write address path
        if (state_r.mode == ERS_SINGLE) begin                     // R4
            mem_q = mem[state_r.wr.addr];
        end
        if (wr_en) begin                                          // R6
            state_nxt.wr = wr_in;                                 // R1
            // Self-timed strobe from the registered request
            mem_we = state_r.wr.req && state_r.wr.we
                     && state_r.mode != ERS_LUT && !state_r.cfg;  // R8 R2
        end
        if (rd_en) begin                                          // R6 R5
            state_nxt.rd = rd_in;                                 // R1
            state_nxt.rd_stage = (state_r.mode == ERS_SINGLE)
                                 ? state_r.wr.req : state_r.rd.req;
            if (state_nxt.rd_stage) begin
                state_nxt.dout = mem_q & width_mask(state_r.width); // R9 R3
            end
            state_nxt.dvalid = state_nxt.rd_stage;                // R9
        end
        // Bus data phase
        if (state_r.ap.sel && state_r.ap.write) begin
            unique case (state_r.ap.addr)
                ERS_OFF_CTRL: begin
                    state_nxt.cfg = hwdata[ERS_CTRL_CFG];
                    state_nxt.mode = hwdata[ERS_CTRL_LUT] ? ERS_LUT :
                                     hwdata[ERS_CTRL_DUAL] ? ERS_DUAL : ERS_SINGLE;
                end
                ERS_OFF_WIDTH: begin
                    // Zero or over-wide widths dropped, keeping a sane mask
                    if (hwdata[4:0] != 5'h00 && hwdata[4:0] <= ERS_WIDTH_RST) begin
                        state_nxt.width = hwdata[4:0];            // R7
                    end
                end
                ERS_OFF_LDADDR: state_nxt.ld_addr = hwdata[ERS_AW-1:0];
                ERS_OFF_LDDATA: begin
                    // Preload only while configuring
                    if (state_r.cfg) begin                        // R2
                        mem_we = 1'b1;
                        mem_wa = state_r.ld_addr;
                        mem_wd = hwdata[ERS_DW-1:0];
                        state_nxt.ld_addr = state_r.ld_addr + 1'b1;
                    end
                end
                default: ;
            endcase
        end
        state_nxt.ap = '0;
        if (hsel && hready && htrans == ERS_HTRANS_NONSEQ) begin
            state_nxt.ap.sel = 1'b1;
            state_nxt.ap.write = hwrite;
            state_nxt.ap.addr = haddr[7:0];
            state_nxt.hrdata = '0;
            if (!hwrite) begin
                unique case (haddr[7:0])
                    ERS_OFF_CTRL: state_nxt.hrdata = {29'h0000_0000, state_r.cfg,
                        state_r.mode == ERS_LUT, state_r.mode == ERS_DUAL};
                    ERS_OFF_STATUS: state_nxt.hrdata = {15'h0000, state_r.dvalid,
                        state_r.dout};
                    ERS_OFF_WIDTH: state_nxt.hrdata = {27'h000_0000, state_r.width};
                    ERS_OFF_LDADDR: state_nxt.hrdata = {24'h00_0000, state_r.ld_addr};
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_r <= '0;
            state_r.mode <= ERS_SINGLE;
            state_r.width <= ERS_WIDTH_RST;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // Memory array holds contents through reset
    always_ff @(posedge core_clk) begin
        if (clk_en && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign rd_data   = state_r.dout;
    assign rd_valid  = state_r.dvalid;
    assign hrdata    = state_r.hrdata;
    // Zero-wait slave: every transfer ends in its data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ****************************************
    // Checks
    // ****************************************
    a_rd_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
        (!rd_en || !clk_en) |=> $stable(rd_data) && $stable(rd_valid))
        else $error("read section changed while disabled");
    a_rd_latency: assert property (@(posedge core_clk) disable iff (!reset_n) // R9
        (clk_en && rd_en && state_r.mode == ERS_DUAL && state_r.rd.req)
        |=> rd_valid)
        else $error("read data not presented after enabled edge");
    a_wr_capture: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
        (clk_en && wr_en) |=> state_r.wr == $past(wr_in))
        else $error("write inputs not captured");
    a_lut_ro: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
        (state_r.mode == ERS_LUT && !state_r.cfg && !state_r.ap.sel) |-> !mem_we)
        else $error("lookup table written outside config");
    a_strobe_src: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
        (mem_we && !state_r.ap.sel) |-> (state_r.wr.req && state_r.wr.we && wr_en))
        else $error("write strobe without registered request");
    a_width_lim: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
        (state_r.width != 5'h00) && (state_r.width <= ERS_WIDTH_RST))
        else $error("width outside range");
    // Mask applies at the read edge; a later width change leaves old data alone
    a_width_mask: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
        (clk_en && rd_en && state_nxt.rd_stage)
        |=> (rd_data & ~width_mask($past(state_r.width))) == '0)
        else $error("read data wider than width");
    a_single_path: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
        (clk_en && rd_en && state_r.mode == ERS_SINGLE && state_r.wr.req) |=> rd_valid)
        else $error("single port read not taken from shared path");
    a_lut_read: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
        (clk_en && rd_en && state_r.mode == ERS_LUT && state_r.rd.req) |=> rd_valid)
        else $error("lookup table read not answered");
    // Preload pointer walks one word per stored entry
    a_ld_incr: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
        (clk_en && state_r.cfg && state_r.ap.sel && state_r.ap.write
         && state_r.ap.addr == ERS_OFF_LDDATA) |=> state_r.ld_addr == $past(state_r.ld_addr) + 1'b1)
        else $error("preload address did not advance");
    // Global freeze must hold every register, bus state too
    a_freeze_all: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
        !clk_en |=> $stable(state_r))
        else $error("state moved while clock enable low");
    a_dual_rate: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
        (clk_en && !wr_en && rd_en) |=> $stable(state_r.wr))
        else $error("write section moved with read enable only");
endmodule
`default_nettype wire

// File: tb/ers_user.sv
// Purpose: User logic model driving the RAM block's memory ports
// Assumes: Tasks are entered just after a rising core_clk edge
// Notes:   Released lines carry inverted values, never stale ones
`default_nettype none
module ers_user
    import ers_pkg::*;
(
    input  wire logic core_clk,
    output logic      wr_en,
    output logic      rd_en,
    output ers_wr_type wr_in,
    output ers_rd_type rd_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_en = 1'b1;
        rd_en = 1'b1;
        wr_in = '0;
        rd_in = '0;
    end
    // ****
    // Requests, synchronous to core_clk
    // ****
    task automatic put(input logic s, input logic w, input logic [7:0] a, input logic [15:0] d);
        if (s) wr_in <= '{req: 1'b1, we: w, addr: a, data: d};
        if (!s) rd_in <= '{req: 1'b1, addr: a};
        @(posedge core_clk);
        // Second edge lets the write land or the read answer
        if (s) wr_in <= '{req: 1'b0, we: 1'b0, addr: ~a, data: ~d};
        if (!s) rd_in <= '{req: 1'b0, addr: ~a};
        @(posedge core_clk);
    endtask
    // Section enables, changed right after a rising edge
    task automatic enable(input logic w, input logic r);
        wr_en <= w;
        rd_en <= r;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the embedded RAM block
// Assumes: Zero-wait bus slave; one core clock
// Notes:   Bus and memory port tasks feed one check task
`default_nettype none
module tb_top
    import ers_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
    logic             hsel = 1'b0, hwrite = 1'b0, rd_valid, hreadyout, hresp;
    logic [1:0]       htrans = 2'h0;
    logic [2:0]       hsize = 3'h0;
    logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [15:0]      rd_data;
    wire logic        wr_en, rd_en;
    wire ers_wr_type  wr_in;
    wire ers_rd_type  rd_in;
    int               miscompares = 0, checks_done = 0;
    ers_user i_user (.core_clk, .wr_en, .rd_en, .wr_in, .rd_in);
    ers_ram i_dut (.core_clk, .reset_n, .clk_en, .wr_en, .rd_en, .wr_in, .rd_in, .rd_data,
        .rd_valid, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp);
    initial forever #20 core_clk = ~core_clk;
    // ****
    // Access tasks
    // ****
    task automatic close_out;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= ERS_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= ERS_HSIZE_WORD;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rv, e);
    endtask
    task automatic mrd(input logic s, input logic [7:0] a, input logic [15:0] e);
        i_user.put(s, 1'b0, a, 16'h0);
        // Falling edge: read data has settled, next stimulus stays on a rising edge
        @(negedge core_clk);
        check(rd_data, e);
        check(rd_valid, 32'(rd_en));
        @(posedge core_clk);
    endtask
    // ****
    // Scenarios
    // ****
    initial begin
        logic [7:0] ad [5];
        ad = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h00};
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        check(hresp, 32'h0);
        check(rd_valid, 32'h0);
        rd(ERS_OFF_CTRL, 32'h0);
        rd(ERS_OFF_WIDTH, {27'h0, ERS_WIDTH_RST});
        rd(8'h20, 32'h0);
        i_user.put(1'b1, 1'b1, 8'h05, 16'hA5C3);
        i_user.put(1'b1, 1'b1, 8'h06, 16'h5A3C);
        mrd(1'b1, 8'h05, 16'hA5C3);
        mrd(1'b1, 8'h06, 16'h5A3C);
        // Idle enabled read edge has cleared valid; data stands
        rd(ERS_OFF_STATUS, 32'h0000_5A3C);
        bus(1'b1, ERS_OFF_CTRL, 32'h1);
        i_user.put(1'b1, 1'b1, ad[0], {ad[0], ~ad[0]});
        for (int i = 1; i < 5; i++) begin
            fork
                if (i < 4) i_user.put(1'b1, 1'b1, ad[i], {ad[i], ~ad[i]});
                mrd(1'b0, ad[i-1], {ad[i-1], ~ad[i-1]});
            join
        end
        // Read section frozen: output must keep the last word
        i_user.enable(1'b1, 1'b0);
        mrd(1'b0, ad[1], 16'h7F80);
        i_user.enable(1'b0, 1'b1);
        i_user.put(1'b1, 1'b1, ad[0], 16'h0F0F);
        i_user.enable(1'b1, 1'b1);
        mrd(1'b0, ad[0], 16'h00FF);
        bus(1'b1, ERS_OFF_WIDTH, 32'h8);
        bus(1'b1, ERS_OFF_WIDTH, 32'h0);
        rd(ERS_OFF_WIDTH, 32'h8);
        mrd(1'b0, ad[2], 16'h007F);
        bus(1'b1, ERS_OFF_WIDTH, 32'h10);
        // Global freeze: a write offered while clock enable is low must not land
        clk_en <= 1'b0;
        i_user.put(1'b1, 1'b1, ad[1], 16'h1111);
        clk_en <= 1'b1;
        mrd(1'b0, ad[1], 16'hFF00);
        // Preload two entries, then try user writes that must not land
        bus(1'b1, ERS_OFF_CTRL, 32'h6);
        bus(1'b1, ERS_OFF_LDADDR, 32'hFE);
        bus(1'b1, ERS_OFF_LDDATA, 32'hBEEF);
        bus(1'b1, ERS_OFF_LDDATA, 32'h1357);
        i_user.put(1'b1, 1'b1, 8'hFF, 16'h0);
        bus(1'b1, ERS_OFF_CTRL, 32'h2);
        i_user.put(1'b1, 1'b1, 8'hFE, 16'h0);
        mrd(1'b0, 8'hFE, 16'hBEEF);
        mrd(1'b0, 8'hFF, 16'h1357);
        close_out();
    end
    initial begin
        repeat (4000) @(posedge core_clk);
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire
